// file: hw/mft_defines.svh
// multi-function timer control: register offsets, field positions, resets
// assumes a 32-bit axi4-lite slave, one register per aligned word
`ifndef MFT_DEFINES_SVH
`define MFT_DEFINES_SVH

// ==========================================
// register byte offsets
`define MFT_OFS_RELOAD_ONE 8'h00
`define MFT_OFS_RELOAD_TWO 8'h04
`define MFT_OFS_MODE_CTRL 8'h08
`define MFT_OFS_IRQ_ENPND 8'h0C
`define MFT_OFS_IRQ_CLEAR 8'h10
`define MFT_OFS_CTR_ONE 8'h14
`define MFT_OFS_CTR_TWO 8'h18

// ==========================================
// mode control fields
`define MFT_MODE_LSB 0
`define MFT_A_POL_BIT 2
`define MFT_B_POL_BIT 3
`define MFT_A_EN_BIT 4
`define MFT_B_EN_BIT 5
`define MFT_A_LEVEL_BIT 6
`define MFT_UNIT_EN_BIT 7

// ==========================================
// reset values and constants
`define MFT_MODE_RESET 8'h00
`define MFT_IRQ_RESET 8'h00
`define MFT_CLEAR_READ 8'hFF
`define MFT_PRESET_VAL 16'hFFFF
`define MFT_PRESC_RESET 5'h00

`endif

// file: hw/mft_pkg.sv
// multi-function timer control: shared types
// assumes mft_defines.svh for numeric constants
package mft_pkg;

	typedef enum logic [1:0]
	{
		MFT_MODE_PWM = 2'h0,
		MFT_MODE_DUAL_CAP = 2'h1,
		MFT_MODE_DUAL_CTR = 2'h2,
		MFT_MODE_SINGLE_CAP = 2'h3
	} mft_mode_t;

	// hardware events from the counter core
	typedef struct packed
	{
		logic ctr_one_underflow;
		logic [3:0] src_set;
		logic ctr_one_write;
		logic [15:0] ctr_one_value;
		logic ctr_two_write;
		logic [15:0] ctr_two_value;
	} mft_events_t;

	// control seen by the counter core
	typedef struct packed
	{
		logic unit_enable;
		logic count_gate;
		logic preset_one;
		logic preset_two;
		logic [4:0] prescale_count;
	} mft_core_ctl_t;

	typedef enum logic [1:0]
	{
		MFT_RD_IDLE,
		MFT_RD_RESP
	} mft_rd_state_t;

endpackage

// file: hw/mft_ctrl.sv
// multi-function timer control block: registers, pin logic, interrupts
// assumes axi4-lite master on aclk; counter core supplies events
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mft_defines.svh"

// Function
// (R1) reload/capture register one, 16-bit read/write
// (R2) reload/capture register two, 16-bit read/write
// (R3) reload/capture registers are not reset
// (R4) two-bit mode field selects one of four modes
// (R5) mode control register clears to zero on reset
// (R6) pin a polarity: 1 rising, 0 falling
// (R7) pin b polarity: 0 falling, 1 rising
// (R8) pulse-accumulate counts while pin b matches polarity level
// (R9) mode two with pin a enable: edge presets counter one
// (R10) pin a is pwm output in modes 1,3,4 when enabled
// (R11) pin b edge presets counter one (mode 2) or two (mode 4)
// (R12) pin b enable ignored in modes one and three
// (R13) pin a level bit drives pwm; software write beats hardware
// (R14) pin a level bit has no effect while pin a is input
// (R15) unit disable stops counter clocks, makes pin a input
// (R16) while disabled ignore writes to counters, reloads, pendings
// (R17) disabling clears prescaler count and all pending flags
// (R18) irq register: enables in bits 7:4, pendings in 3:0
// (R19) irq register resets to zero
// (R20) pending set by hardware or writing one; zero ignored
// (R21) request only when the source enable bit is one
// (R22) clear register: writing one clears matching pending flag
// (R23) clear register reads as all ones
// (R24) software must not read-modify-write the clear register
// (R25) sources a,b,c form request one, d forms request two
// (R26) pwm pin a toggles on counter one underflow
// (R27) request line high while any enabled source pending
module mft_ctrl
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mft_pkg::mft_events_t core_events,
	output mft_pkg::mft_core_ctl_t core_ctl,
	input wire logic pin_a_in,
	output logic pin_a_out,
	output logic pin_a_oe,
	input wire logic pin_b_in,
	output logic irq_one,
	output logic irq_two
);
	import mft_pkg::*;

	// ==========================================
	// state
	logic [15:0] reload_one_ff;
	logic [15:0] reload_two_ff;
	logic [7:0] mode_ctrl_ff;
	logic [7:0] irq_ff;
	logic [4:0] presc_ff;
	logic pin_a_d_ff;
	logic pin_b_d_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [1:0] bresp_ff;
	logic [15:0] ctr_one_shadow_ff;
	logic [15:0] ctr_two_shadow_ff;

	mft_mode_t mode;
	logic unit_on;
	logic a_en;
	logic b_en;
	logic a_edge;
	logic b_edge;
	logic a_is_pwm;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_mode;
	logic wr_irq;
	logic wr_clr;
	logic [3:0] hw_set;
	logic [3:0] sw_set;
	logic [3:0] sw_clr;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `MFT_OFS_RELOAD_ONE) || (a == `MFT_OFS_RELOAD_TWO)
			|| (a == `MFT_OFS_MODE_CTRL) || (a == `MFT_OFS_IRQ_ENPND)
			|| (a == `MFT_OFS_IRQ_CLEAR) || (a == `MFT_OFS_CTR_ONE)
			|| (a == `MFT_OFS_CTR_TWO);
	endfunction

	// qualifying edge: polarity 1 rising, 0 falling
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic pol);
		edge_hit = pol ? (!prev && cur) : (prev && !cur);
	endfunction

	// ==========================================
	// decode
	assign mode = mft_mode_t'(mode_ctrl_ff[`MFT_MODE_LSB +: 2]); // [R4]
	assign unit_on = mode_ctrl_ff[`MFT_UNIT_EN_BIT];
	assign a_en = mode_ctrl_ff[`MFT_A_EN_BIT];
	assign b_en = mode_ctrl_ff[`MFT_B_EN_BIT] &&
		(mode == MFT_MODE_DUAL_CAP || mode == MFT_MODE_SINGLE_CAP); // [R12]
	assign a_edge = edge_hit(pin_a_d_ff, pin_a_in,
		mode_ctrl_ff[`MFT_A_POL_BIT]); // [R6]
	assign b_edge = edge_hit(pin_b_d_ff, pin_b_in,
		mode_ctrl_ff[`MFT_B_POL_BIT]); // [R7]
	assign a_is_pwm = unit_on && a_en && mode != MFT_MODE_DUAL_CAP; // [R10]

	// ==========================================
	// axi4-lite write channel
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
	assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
	assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
	assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready))
		&& (w_held_ff || (s_axi_wvalid && s_axi_wready));
	assign wr_mode = wr_fire && wr_strb[0] && wr_addr == `MFT_OFS_MODE_CTRL;
	assign wr_irq = wr_fire && wr_strb[0] && wr_addr == `MFT_OFS_IRQ_ENPND;
	assign wr_clr = wr_fire && wr_strb[0] && wr_addr == `MFT_OFS_IRQ_CLEAR;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
		end
		else
		begin
			if (wr_fire)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= addr_known(wr_addr) ? 2'h0 : 2'h2;
			end
			else
			begin
				if (s_axi_awvalid && s_axi_awready)
				begin
					aw_held_ff <= 1'b1;
					aw_addr_ff <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready)
				begin
					w_held_ff <= 1'b1;
					w_data_ff <= s_axi_wdata;
					w_strb_ff <= s_axi_wstrb;
				end
				if (bvalid_ff && s_axi_bready)
					bvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ==========================================
	// mode control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_ctrl_ff <= `MFT_MODE_RESET; // [R5]
		else if (wr_mode)
			mode_ctrl_ff <= wr_data[7:0]; // [R13]
		else if (a_is_pwm && core_events.ctr_one_underflow)
			mode_ctrl_ff[`MFT_A_LEVEL_BIT] <=
				!mode_ctrl_ff[`MFT_A_LEVEL_BIT]; // [R26]
	end

	// ==========================================
	// reload/capture registers, no reset [R3]
	always_ff @(posedge aclk)
	begin
		if (wr_fire && unit_on && wr_addr == `MFT_OFS_RELOAD_ONE) // [R16]
		begin
			if (wr_strb[0])
				reload_one_ff[7:0] <= wr_data[7:0]; // [R1]
			if (wr_strb[1])
				reload_one_ff[15:8] <= wr_data[15:8];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (wr_fire && unit_on && wr_addr == `MFT_OFS_RELOAD_TWO) // [R16]
		begin
			if (wr_strb[0])
				reload_two_ff[7:0] <= wr_data[7:0]; // [R2]
			if (wr_strb[1])
				reload_two_ff[15:8] <= wr_data[15:8];
		end
	end

	// counter values mirrored for readback; writes to them get OKAY but reach nothing
	always_ff @(posedge aclk)
	begin
		ctr_one_shadow_ff <= core_events.ctr_one_value;
		ctr_two_shadow_ff <= core_events.ctr_two_value;
	end

	// ==========================================
	// interrupt enable/pending
	assign hw_set = unit_on ? core_events.src_set : 4'h0;
	assign sw_set = (wr_irq && unit_on) ? wr_data[3:0] : 4'h0; // [R20]
	assign sw_clr = (wr_clr && unit_on) ? wr_data[3:0] : 4'h0; // [R22]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_ff <= `MFT_IRQ_RESET; // [R19]
		else
		begin
			if (wr_irq)
				irq_ff[7:4] <= wr_data[7:4]; // [R18]
			if (wr_mode && !wr_data[`MFT_UNIT_EN_BIT])
				irq_ff[3:0] <= 4'h0; // [R17]
			else
				irq_ff[3:0] <= (irq_ff[3:0] & ~sw_clr) | sw_set | hw_set;
		end
	end

	assign irq_one = |(irq_ff[2:0] & irq_ff[6:4]); // [R25] [R27]
	assign irq_two = irq_ff[3] & irq_ff[7]; // [R21]

	// ==========================================
	// pins and prescaler
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_a_d_ff <= 1'b0;
			pin_b_d_ff <= 1'b0;
		end
		else
		begin
			pin_a_d_ff <= pin_a_in;
			pin_b_d_ff <= pin_b_in;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !unit_on)
			presc_ff <= `MFT_PRESC_RESET; // [R17]
		else
			presc_ff <= presc_ff + 5'h01;
	end

	assign pin_a_oe = a_is_pwm; // [R15]
	assign pin_a_out = a_is_pwm && mode_ctrl_ff[`MFT_A_LEVEL_BIT]; // [R14]

	always_comb
	begin
		core_ctl.unit_enable = unit_on; // [R15]
		core_ctl.count_gate = (pin_b_in == mode_ctrl_ff[`MFT_B_POL_BIT]); // [R8]
		core_ctl.preset_one = unit_on && mode == MFT_MODE_DUAL_CAP &&
			((a_en && a_edge) || (b_en && b_edge)); // [R9] [R11]
		core_ctl.preset_two = unit_on && mode == MFT_MODE_SINGLE_CAP &&
			b_en && b_edge; // [R11]
		core_ctl.prescale_count = presc_ff;
	end

	// ==========================================
	// axi4-lite read channel
	assign s_axi_arready = !rvalid_ff;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_known(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
				`MFT_OFS_RELOAD_ONE: rdata_ff <= {16'h0000, reload_one_ff};
				`MFT_OFS_RELOAD_TWO: rdata_ff <= {16'h0000, reload_two_ff};
				`MFT_OFS_MODE_CTRL: rdata_ff <= {24'h000000, mode_ctrl_ff};
				`MFT_OFS_IRQ_ENPND: rdata_ff <= {24'h000000, irq_ff};
				`MFT_OFS_IRQ_CLEAR: rdata_ff <= {24'h000000, `MFT_CLEAR_READ}; // [R23]
				`MFT_OFS_CTR_ONE: rdata_ff <= {16'h0000, ctr_one_shadow_ff};
				`MFT_OFS_CTR_TWO: rdata_ff <= {16'h0000, ctr_two_shadow_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ==========================================
	// assertions
	a_pend_clear_off: assert property (@(posedge aclk) // [R17]
		disable iff (!aresetn)
		(wr_mode && !wr_data[7]) |=> irq_ff[3:0] == 4'h0)
		else $error("pending not cleared on disable");
	a_irq_two_map: assert property (@(posedge aclk) // [R25]
		disable iff (!aresetn)
		irq_two == (irq_ff[3] && irq_ff[7]))
		else $error("irq two mismatch");
	a_zero_no_clear: assert property (@(posedge aclk) // [R20]
		disable iff (!aresetn)
		(wr_irq && !wr_clr && !wr_mode && irq_ff[0]) |=> irq_ff[0])
		else $error("write zero cleared pending");
	a_clr_reads_ones: assert property (@(posedge aclk) // [R23]
		disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10)
		|=> rdata_ff[7:0] == 8'hFF)
		else $error("clear reg read not ones");
	a_pin_a_input: assert property (@(posedge aclk) // [R15]
		disable iff (!aresetn)
		!mode_ctrl_ff[7] |-> !pin_a_oe)
		else $error("pin a driven while disabled");
	a_presc_zero: assert property (@(posedge aclk) // [R17]
		disable iff (!aresetn)
		!unit_on |=> presc_ff == 5'h00)
		else $error("prescaler not cleared");
	a_toggle_pwm: assert property (@(posedge aclk) // [R26]
		disable iff (!aresetn)
		(a_is_pwm && core_events.ctr_one_underflow && !wr_mode)
		|=> mode_ctrl_ff[6] != $past(mode_ctrl_ff[6]))
		else $error("pin a did not toggle");
	a_pwm_only_mode: assert property (@(posedge aclk) // [R10]
		disable iff (!aresetn)
		(mode == MFT_MODE_DUAL_CAP) |-> !pin_a_oe)
		else $error("pin a driven in capture mode");
	a_preset_b_mode: assert property (@(posedge aclk) // [R11]
		disable iff (!aresetn)
		core_ctl.preset_two
		|-> (mode_ctrl_ff[1:0] == 2'h3 && mode_ctrl_ff[5]))
		else $error("bad counter two preset");
	a_mode_reset: assert property (@(posedge aclk) // [R5]
		!aresetn |=> mode_ctrl_ff == 8'h00 && irq_ff == 8'h00)
		else $error("reset values wrong");
	a_sw_beats_hw: assert property (@(posedge aclk) // [R13]
		disable iff (!aresetn)
		wr_mode |=> mode_ctrl_ff == $past(wr_data[7:0]))
		else $error("mode write lost");
	a_reload_locked: assert property (@(posedge aclk) // [R16]
		disable iff (!aresetn)
		(wr_fire && !unit_on && wr_addr == 8'h00)
		|=> reload_one_ff == $past(reload_one_ff))
		else $error("reload written while disabled");
	a_preset_one_mode: assert property (@(posedge aclk) // [R9]
		disable iff (!aresetn)
		core_ctl.preset_one |-> (unit_on && mode == MFT_MODE_DUAL_CAP))
		else $error("bad counter one preset");
endmodule
`default_nettype wire

// file: testbench/mft_ctrl_tb_top.sv
// testbench for mft_ctrl: register, interrupt, pin and preset tests
// assumes mft_pkg and mft_defines.svh are compiled and on the path
`timescale 1ns/100ps
`default_nettype none
`include "mft_defines.svh"

module mft_ctrl_tb_top;
	import mft_pkg::*;
	// ==========================================
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq_one, irq_two;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic pin_a_in = 1'b0;
	logic pin_b_in = 1'b0;
	logic pin_a_out, pin_a_oe, p1, p2;
	mft_events_t ev = '0;
	mft_core_ctl_t core_ctl;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] d;
	logic [1:0] r;
	logic [1:0] b;

	always #25 aclk = ~aclk;

	mft_ctrl i_mft_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_events(ev),
		.core_ctl(core_ctl), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out),
		.pin_a_oe(pin_a_oe), .pin_b_in(pin_b_in), .irq_one(irq_one),
		.irq_two(irq_two));

	// ==========================================
	// tasks
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		b = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		rd(a);
		chk(nm, d, exp);
	endtask

	// one-cycle pulse on the hardware event inputs
	task automatic pulse(input logic [3:0] s, input logic uf);
		@(posedge aclk);
		ev.src_set <= s;
		ev.ctr_one_underflow <= uf;
		@(posedge aclk);
		ev.src_set <= 4'h0;
		ev.ctr_one_underflow <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	// drive pins, then gather preset pulses over eight cycles
	task automatic pins(input logic a, input logic b);
		@(posedge aclk);
		pin_a_in <= a;
		pin_b_in <= b;
		p1 = 1'b0;
		p2 = 1'b0;
		repeat (8)
		begin
			@(posedge aclk);
			p1 = p1 | core_ctl.preset_one;
			p2 = p2 | core_ctl.preset_two;
		end
	endtask

	// ==========================================
	// timeout
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end

	// ==========================================
	// main sequence
	initial
	begin
		do_reset();
		rchk("mode", `MFT_OFS_MODE_CTRL, 32'h0);
		rchk("irq", `MFT_OFS_IRQ_ENPND, 32'h0);
		rchk("clear", `MFT_OFS_IRQ_CLEAR, 32'hFF);
		chk("oe", pin_a_oe, 1'b0);
		rd(8'h40);
		chk("resp", {d[31:2], r}, 32'h2);
		wr(`MFT_OFS_MODE_CTRL, 32'h80);
		wr(`MFT_OFS_RELOAD_ONE, 32'h1234);
		wr(`MFT_OFS_RELOAD_TWO, 32'hABCD);
		rchk("rl1", `MFT_OFS_RELOAD_ONE, 32'h1234);
		rchk("rl2", `MFT_OFS_RELOAD_TWO, 32'hABCD);
		do_reset();
		rchk("rl1 kept", `MFT_OFS_RELOAD_ONE, 32'h1234);
		rchk("mode", `MFT_OFS_MODE_CTRL, 32'h0);
		wr(`MFT_OFS_RELOAD_ONE, 32'h5555);
		chk("off resp", b, 2'h0);
		wr(`MFT_OFS_IRQ_ENPND, 32'h0F);
		rchk("rl1 off", `MFT_OFS_RELOAD_ONE, 32'h1234);
		rchk("irq off", `MFT_OFS_IRQ_ENPND, 32'h0);
		wr(`MFT_OFS_MODE_CTRL, 32'h80);
		wr(`MFT_OFS_IRQ_ENPND, 32'h0F);
		rchk("pnd set", `MFT_OFS_IRQ_ENPND, 32'h0F);
		wr(`MFT_OFS_IRQ_ENPND, 32'h00);
		rchk("pnd zero", `MFT_OFS_IRQ_ENPND, 32'h0F);
		chk("irq1 off", {irq_one, irq_two}, 2'b00);
		wr(`MFT_OFS_IRQ_ENPND, 32'h1F);
		chk("irq a", {irq_one, irq_two}, 2'b10);
		wr(`MFT_OFS_IRQ_CLEAR, 32'h01);
		rchk("clr a", `MFT_OFS_IRQ_ENPND, 32'h1E);
		chk("irq1 b c", irq_one, 1'b0);
		wr(`MFT_OFS_IRQ_CLEAR, 32'h00);
		rchk("clr 0", `MFT_OFS_IRQ_ENPND, 32'h1E);
		wr(`MFT_OFS_IRQ_ENPND, 32'h80);
		rchk("en d", `MFT_OFS_IRQ_ENPND, 32'h8E);
		chk("irq d", {irq_one, irq_two}, 2'b01);
		wr(`MFT_OFS_IRQ_CLEAR, 32'h0F);
		pulse(4'h2, 1'b0);
		rchk("hw b", `MFT_OFS_IRQ_ENPND, 32'h82);
		chk("irq1 mask", irq_one, 1'b0);
		wr(`MFT_OFS_IRQ_ENPND, 32'hA0);
		chk("irq1 b", irq_one, 1'b1);
		wr(`MFT_OFS_MODE_CTRL, 32'h00);
		rchk("dis pnd", `MFT_OFS_IRQ_ENPND, 32'hA0);
		chk("presc", core_ctl.prescale_count, 5'h00);
		chk("unit", core_ctl.unit_enable, 1'b0);
		for (int m = 0; m < 4; m++)
		begin
			wr(`MFT_OFS_MODE_CTRL, 32'h80 | m);
			rchk("mode sel", `MFT_OFS_MODE_CTRL, 32'h80 | m);
		end
		wr(`MFT_OFS_MODE_CTRL, 32'h90);
		chk("pwm", {pin_a_oe, pin_a_out}, 2'b10);
		pulse(4'h0, 1'b1);
		chk("toggle", pin_a_out, 1'b1);
		rchk("level", `MFT_OFS_MODE_CTRL, 32'hD0);
		wr(`MFT_OFS_MODE_CTRL, 32'hD1);
		chk("cap oe", pin_a_oe, 1'b0);
		chk("cap level", pin_a_out, 1'b0);
		wr(`MFT_OFS_MODE_CTRL, 32'h10);
		chk("dis oe", pin_a_oe, 1'b0);
		wr(`MFT_OFS_MODE_CTRL, 32'h95);
		pins(1'b1, 1'b0);
		chk("a rise", {p1, p2}, 2'b10);
		pins(1'b0, 1'b0);
		chk("a fall", {p1, p2}, 2'b00);
		wr(`MFT_OFS_MODE_CTRL, 32'hAB);
		pins(1'b0, 1'b1);
		chk("b rise", {p1, p2}, 2'b01);
		pins(1'b0, 1'b0);
		chk("b fall", {p1, p2}, 2'b00);
		wr(`MFT_OFS_MODE_CTRL, 32'hA9);
		pins(1'b0, 1'b1);
		chk("b mode2", {p1, p2}, 2'b10);
		pins(1'b0, 1'b0);
		wr(`MFT_OFS_MODE_CTRL, 32'hA8);
		pins(1'b0, 1'b1);
		chk("b mode1", {p1, p2}, 2'b00);
		chk("gate hi", core_ctl.count_gate, 1'b1);
		wr(`MFT_OFS_MODE_CTRL, 32'hA0);
		chk("gate lo", core_ctl.count_gate, 1'b0);
		results();
	end
endmodule
`default_nettype wire
